/* File: pcc_pkg.sv */
package pcc_pkg;
	// register offsets
	localparam logic [7:0] MODE_CTRL_ADDR    = 8'h04;
	localparam logic [7:0] CTRL_TWO_ADDR     = 8'h05;
	localparam logic [7:0] RAIL_TARGET_ADDR  = 8'h06;
	localparam logic [7:0] SLEW_SELECT_ADDR  = 8'h07;
	localparam logic [7:0] AUX_VOLTAGE_ADDR  = 8'h08;
	// reset values
	localparam logic [7:0] MODE_CTRL_RESET   = 8'hB0;
	localparam logic [7:0] CTRL_TWO_RESET    = 8'h40;
	localparam logic [7:0] TARGET_BASE_RESET = 8'h14;
	localparam logic [7:0] TARGET_PIN_BITS   = 8'h0A;
	localparam logic [7:0] SLEW_RESET        = 8'h06;
	localparam logic [7:0] AUX_RESET         = 8'h23;
	// field positions
	localparam int LOW_RIPPLE_BIT  = 3;
	localparam int FIXED_MEM_BIT   = 2;
	localparam int FIXED_SYS_BIT   = 1;
	localparam int FIXED_PROC_BIT  = 0;
	localparam int GO_BIT          = 7;
	localparam int PIN_SELECT_BIT  = 6;
	localparam int BLEED_MEM_BIT   = 2;
	localparam int BLEED_SYS_BIT   = 1;
	localparam int BLEED_PROC_BIT  = 0;
	localparam int FIRST_AUX_LSB   = 0;
	localparam int SECOND_AUX_LSB  = 4;
	// writable masks
	localparam logic [7:0] CTRL_TWO_MASK  = 8'hC7;
	localparam logic [7:0] TARGET_MASK    = 8'h1F;
	localparam logic [7:0] SLEW_MASK      = 8'h07;
	localparam logic [7:0] AUX_MASK       = 8'h77;
	// slew timing: 25 mV step at 0.15 mV/us is 166.67 us
	localparam int STEP_MV_X100     = 2500;
	localparam int SLOWEST_RATE_UV  = 150;
	localparam int CLOCK_MHZ        = 250;
	localparam int STEP_NS_SLOWEST  = (STEP_MV_X100 * 10000) / SLOWEST_RATE_UV;
	localparam int STEP_CYCLES_SLOW = (STEP_NS_SLOWEST * CLOCK_MHZ) / 1000;
	localparam logic [2:0] SLEW_IMMEDIATE = 3'h7;
	localparam logic [4:0] PIN_LOW_CODE   = 5'h14;
	localparam logic [4:0] PIN_HIGH_CODE  = 5'h1E;
endpackage

/* File: pcc_step_timer.sv */
// paces one 25 mV step; period halves for every slew code increment
module pcc_step_timer
	import pcc_pkg::*;
#(
	parameter int SLOW_CYCLES = STEP_CYCLES_SLOW
) (
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic       run_in,
	input  wire logic [2:0] slew_in,
	output logic            tick_out
);
	localparam int CW = $clog2(SLOW_CYCLES + 1);
	logic [CW-1:0] count_reg;
	logic [CW-1:0] limit;

	// shift is exact for rates that double; truncation error is under a cycle
	always_comb begin
		limit = CW'(SLOW_CYCLES >> slew_in);
		if (limit == '0) begin
			limit = CW'(1);
		end
	end

	// counter restarts whenever no move is running
	always_ff @(posedge clk_in) begin
		if (!nrst_in || !run_in) begin
			count_reg <= '0;
			tick_out  <= 1'b0;
		end else if (count_reg + CW'(1) >= limit) begin
			count_reg <= '0;
			tick_out  <= 1'b1;
		end else begin
			count_reg <= count_reg + CW'(1);
			tick_out  <= 1'b0;
		end
	end
endmodule

/* File: pcc_converter_regs.sv */
// What this block does
// R1 - one low-ripple bit picks skip-mode tuning for all three bucks
// R2 - per-buck fixed-frequency bits force PWM, clear allows PWM/PFM
// R3 - writing go starts processor rail move toward target at chosen slew
// R4 - go self-clears when internal code reaches target code
// R5 - pin-select bit picks register code or default pin for processor rail
// R6 - with pin source, pin low/high gives 1.3 V or 1.55 V
// R7 - per-buck bleed bits discharge output when that buck is disabled
// R8 - target code resets to 14h or 1Eh following the default pin
// R9 - target reloads on lockout, both bucks off, warm reset, por, backup low
// R10 - five-bit code: 0.8 V plus 25 mV per step, top code 1.575 V
// R11 - slew code doubles rate from 0.15 to 9.6 mV/us, 111 immediate
// R12 - two three-bit aux regulator voltage codes at bits 6:4 and 2:0
// R13 - aux voltage register resets to 23h
// R14 - processor fault flag held at zero while a move runs
// R15 - move steps internal code one 25 mV step at a slew-paced interval
module pcc_converter_regs
	import pcc_pkg::*;
#(
	parameter int SLOW_CYCLES = STEP_CYCLES_SLOW
) (
	// clock and reset (reset stands for undervoltage lockout)
	input  wire logic       CLOCK_IN,
	input  wire logic       NRST_IN,
	// register port from the serial interface
	input  wire logic [7:0] REG_ADDR_IN,
	input  wire logic [7:0] REG_WDATA_IN,
	input  wire logic       REG_WRITE_IN,
	input  wire logic       REG_READ_IN,
	output logic      [7:0] REG_RDATA_OUT,
	// system events and pins
	input  wire logic       PROCESSOR_DEFAULT_PIN_IN,
	input  wire logic       SYSTEM_BUCK_ENABLED_IN,
	input  wire logic       PROCESSOR_BUCK_ENABLED_IN,
	input  wire logic       WARM_RESET_N_IN,
	input  wire logic       POWER_ON_RESET_ACTIVE_IN,
	input  wire logic       BACKUP_RAIL_LOW_IN,
	input  wire logic       PROCESSOR_RAIL_UNDER_IN,
	// converter controls
	output logic            LOW_RIPPLE_OUT,
	output logic      [2:0] FORCED_FIXED_FREQUENCY_OUT,
	output logic      [2:0] BUCK_BLEED_OUT,
	output logic      [4:0] PROCESSOR_RAIL_CODE_OUT,
	output logic            PROCESSOR_PIN_SOURCE_OUT,
	output logic            MOVE_BUSY_OUT,
	output logic            PROCESSOR_RAIL_FAULT_FLAG_OUT,
	output logic      [2:0] FIRST_AUX_CODE_OUT,
	output logic      [2:0] SECOND_AUX_CODE_OUT
);
	// programmable registers
	logic [7:0] mode_reg;
	logic [7:0] ctrl_two_reg;
	logic [4:0] target_reg;
	logic [2:0] slew_reg;
	logic [7:0] aux_reg;

	// move state and the default-pin sample
	logic [4:0] code_reg;
	logic       pin_reg;
	logic       tick;

	// event and pin decodes
	logic       reload;
	logic       go;
	logic [4:0] pin_default;

	// write strobes, one per mapped register
	logic       wr_mode;
	logic       wr_two;
	logic       wr_target;
	logic       wr_slew;
	logic       wr_aux;

	// move control for the stepping logic, plus the pin source select and the read mux value
	logic       move_run;
	logic       move_done;
	logic       step_up;
	logic       pin_select;
	logic [7:0] read_value;

	// write decodes; unmapped addresses match none of these, so those writes are dropped
	assign wr_mode   = REG_WRITE_IN && REG_ADDR_IN == MODE_CTRL_ADDR;
	assign wr_two    = REG_WRITE_IN && REG_ADDR_IN == CTRL_TWO_ADDR;
	assign wr_target = REG_WRITE_IN && REG_ADDR_IN == RAIL_TARGET_ADDR;
	assign wr_slew   = REG_WRITE_IN && REG_ADDR_IN == SLEW_SELECT_ADDR;
	assign wr_aux    = REG_WRITE_IN && REG_ADDR_IN == AUX_VOLTAGE_ADDR;
	// go is the trigger bit itself; it stays up until the walk lands
	assign go        = ctrl_two_reg[GO_BIT];

	// the pin-select bit steers the rail output away from the stepping code
	assign pin_select = ctrl_two_reg[PIN_SELECT_BIT]; // see R5

	// a move runs only while the internal code still differs from the target
	assign move_run  = go && code_reg != target_reg; // see R3
	assign move_done = go && code_reg == target_reg; // see R4
	// direction is taken afresh each step, so a target rewritten mid-move is followed
	assign step_up   = code_reg < target_reg; // see R15

	// pin-dependent default: bits 3 and 1 follow the pin
	assign pin_default = pin_reg ? PIN_HIGH_CODE : PIN_LOW_CODE; // see R8 see R6

	// any of the system events reloads the target code
	// every event is a level: the target stays at its default while one lasts
	assign reload = !WARM_RESET_N_IN || POWER_ON_RESET_ACTIVE_IN || BACKUP_RAIL_LOW_IN
		|| (!SYSTEM_BUCK_ENABLED_IN && !PROCESSOR_BUCK_ENABLED_IN); // see R9

	// pin level follows the input; a plain input sampled each clock, so reset loads the default picked by that sample
	// the sample is not reset, so reset must last two edges for the default to be right
	always_ff @(posedge CLOCK_IN) begin
		pin_reg <= PROCESSOR_DEFAULT_PIN_IN;
	end

	// mode control register: ripple and fixed-frequency bits
	// phase bits 7:4 are kept for read-back only; phase control lives elsewhere
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			mode_reg <= MODE_CTRL_RESET;
		end else if (wr_mode) begin
			mode_reg <= REG_WDATA_IN;
		end
	end

	// control two: go is set by software and cleared by hardware at completion
	// a write in the completion cycle wins, so software can re-arm at once
	// reserved bits 5:3 are masked off and always read zero
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			ctrl_two_reg <= CTRL_TWO_RESET;
		end else if (wr_two) begin
			ctrl_two_reg <= REG_WDATA_IN & CTRL_TWO_MASK; // see R3
		end else if (move_done) begin
			ctrl_two_reg[GO_BIT] <= 1'b0; // see R4
		end
	end

	// target code; lockout uses the same pin default as the other events
	// reload outranks a software write, so a target written during an event is lost
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN || reload) begin
			target_reg <= pin_default; // see R8 see R9
		end else if (wr_target) begin
			target_reg <= REG_WDATA_IN[4:0]; // see R10
		end
	end

	// slew select; a new rate also paces the step already in progress, as the timer limit follows it at once
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			slew_reg <= SLEW_RESET[2:0];
		end else if (wr_slew) begin
			slew_reg <= REG_WDATA_IN[2:0]; // see R11
		end
	end

	// aux regulator codes; bits 7 and 3 are reserved and stay zero
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			aux_reg <= AUX_RESET; // see R13
		end else if (wr_aux) begin
			aux_reg <= REG_WDATA_IN & AUX_MASK; // see R12
		end
	end

	// internal code walks toward target one step per tick, or jumps at code 111
	// only lockout resets this code, to 14h; the other events leave it, so a later move starts where it stands
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			code_reg <= PIN_LOW_CODE;
		end else if (move_run) begin
			// code 111 lands in one edge; go still needs one more edge to drop
			if (slew_reg == SLEW_IMMEDIATE) begin
				code_reg <= target_reg; // see R11
			end else if (tick) begin
				// one step is 25 mV; no wrap, as the target bounds the walk
				if (step_up) begin
					code_reg <= code_reg + 5'h01; // see R15
				end else begin
					code_reg <= code_reg - 5'h01; // see R15
				end
			end
		end
	end

	// step pacing; the timer is held cleared whenever no move is running
	pcc_step_timer #(
		.SLOW_CYCLES (SLOW_CYCLES)
	) u_pcc_step_timer (
		.clk_in   (CLOCK_IN),
		.nrst_in  (NRST_IN),
		.run_in   (move_run),
		.slew_in  (slew_reg),
		.tick_out (tick)
	);

	// skip-mode tuning is shared by all three bucks
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			LOW_RIPPLE_OUT <= MODE_CTRL_RESET[LOW_RIPPLE_BIT];
		end else begin
			LOW_RIPPLE_OUT <= mode_reg[LOW_RIPPLE_BIT]; // see R1
		end
	end

	// fixed-frequency forcing, ordered memory, system, processor
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			FORCED_FIXED_FREQUENCY_OUT <= {MODE_CTRL_RESET[FIXED_MEM_BIT],
				MODE_CTRL_RESET[FIXED_SYS_BIT], MODE_CTRL_RESET[FIXED_PROC_BIT]};
		end else begin
			FORCED_FIXED_FREQUENCY_OUT <= {mode_reg[FIXED_MEM_BIT],
				mode_reg[FIXED_SYS_BIT], mode_reg[FIXED_PROC_BIT]}; // see R2
		end
	end

	// discharge enables, same order; the analog side applies them only when disabled
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			BUCK_BLEED_OUT <= {CTRL_TWO_RESET[BLEED_MEM_BIT],
				CTRL_TWO_RESET[BLEED_SYS_BIT], CTRL_TWO_RESET[BLEED_PROC_BIT]};
		end else begin
			BUCK_BLEED_OUT <= {ctrl_two_reg[BLEED_MEM_BIT],
				ctrl_two_reg[BLEED_SYS_BIT], ctrl_two_reg[BLEED_PROC_BIT]}; // see R7
		end
	end

	// pin source flag, exported so the analog side can pick its reference
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			PROCESSOR_PIN_SOURCE_OUT <= CTRL_TWO_RESET[PIN_SELECT_BIT];
		end else begin
			PROCESSOR_PIN_SOURCE_OUT <= pin_select; // see R5
		end
	end

	// rail code: pin default while the pin source is chosen, else the stepping code
	// a divider on the pin is not modelled; only the tied-pin codes appear here
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			PROCESSOR_RAIL_CODE_OUT <= PIN_LOW_CODE;
		end else if (pin_select) begin
			PROCESSOR_RAIL_CODE_OUT <= pin_default; // see R6
		end else begin
			PROCESSOR_RAIL_CODE_OUT <= code_reg; // see R5, R10
		end
	end

	// busy lags go by one edge, like every other output
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			MOVE_BUSY_OUT <= CTRL_TWO_RESET[GO_BIT];
		end else begin
			MOVE_BUSY_OUT <= go; // see R3
		end
	end

	// fault is masked for the whole move, so a real droop then goes unreported
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			PROCESSOR_RAIL_FAULT_FLAG_OUT <= 1'b0;
		end else begin
			PROCESSOR_RAIL_FAULT_FLAG_OUT <= PROCESSOR_RAIL_UNDER_IN && !go; // see R14
		end
	end

	// first aux regulator code
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			FIRST_AUX_CODE_OUT <= AUX_RESET[FIRST_AUX_LSB +: 3]; // see R13
		end else begin
			FIRST_AUX_CODE_OUT <= aux_reg[FIRST_AUX_LSB +: 3]; // see R12
		end
	end

	// second aux regulator code
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			SECOND_AUX_CODE_OUT <= AUX_RESET[SECOND_AUX_LSB +: 3]; // see R13
		end else begin
			SECOND_AUX_CODE_OUT <= aux_reg[SECOND_AUX_LSB +: 3]; // see R12
		end
	end

	// read select; unmapped addresses and reserved bits read zero
	// a read in the same cycle as a write returns the old contents
	always_comb begin
		read_value = 8'h00;
		case (REG_ADDR_IN)
			MODE_CTRL_ADDR:   read_value = mode_reg;
			CTRL_TWO_ADDR:    read_value = ctrl_two_reg;
			RAIL_TARGET_ADDR: read_value = {3'h0, target_reg};
			SLEW_SELECT_ADDR: read_value = {5'h00, slew_reg};
			AUX_VOLTAGE_ADDR: read_value = aux_reg;
			default:          read_value = 8'h00;
		endcase
	end

	// read data is registered and holds until the next read strobe
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			REG_RDATA_OUT <= 8'h00;
		end else if (REG_READ_IN) begin
			REG_RDATA_OUT <= read_value;
		end
	end
endmodule

/* File: pcc_host_model.sv */
// host side of the register port: one byte per access, then an idle cycle
module pcc_host_model (
	input  wire logic       clk,
	output logic      [7:0] addr = 8'h00,
	output logic      [7:0] wdata = 8'h00,
	output logic            wr = 1'b0,
	output logic            rd = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// strobe held across one rising edge; released lines show inverted values
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = w;
		rd = !w;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
endmodule

/* File: pcc_converter_regs_properties.sv */
module pcc_regs_checker #(
	parameter int SLOW_CYCLES = 64
) (
	input wire logic       CLOCK_IN,
	input wire logic       NRST_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic       REG_WRITE_IN,
	input wire logic       REG_READ_IN,
	input wire logic [7:0] REG_RDATA_OUT,
	input wire logic       PROCESSOR_DEFAULT_PIN_IN,
	input wire logic       PROCESSOR_RAIL_UNDER_IN,
	input wire logic       LOW_RIPPLE_OUT,
	input wire logic [2:0] FORCED_FIXED_FREQUENCY_OUT,
	input wire logic [2:0] BUCK_BLEED_OUT,
	input wire logic [4:0] PROCESSOR_RAIL_CODE_OUT,
	input wire logic       PROCESSOR_PIN_SOURCE_OUT,
	input wire logic       MOVE_BUSY_OUT,
	input wire logic       PROCESSOR_RAIL_FAULT_FLAG_OUT,
	input wire logic [2:0] FIRST_AUX_CODE_OUT,
	input wire logic [2:0] SECOND_AUX_CODE_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] age_reg; // edges since reset; outputs lag the pin by two
	always_ff @(posedge CLOCK_IN) begin
		age_reg <= !NRST_IN ? 2'h0 : age_reg + {1'b0, age_reg != 2'h3};
	end
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!NRST_IN);
	// a lone write to one address
	sequence wr_at(logic [7:0] a);
		REG_WRITE_IN && REG_ADDR_IN == a ##1 !REG_WRITE_IN;
	endsequence
	mode_bits_a: assert property (wr_at(8'h04) |-> ##1
		{LOW_RIPPLE_OUT, FORCED_FIXED_FREQUENCY_OUT} == $past(REG_WDATA_IN[3:0], 2))
		else $error("mode outputs wrong");
	bleed_source_a: assert property (wr_at(8'h05) |-> ##1
		PROCESSOR_PIN_SOURCE_OUT == $past(REG_WDATA_IN[6], 2) &&
		BUCK_BLEED_OUT == $past(REG_WDATA_IN[2:0], 2)) else $error("bleed or source wrong");
	aux_codes_a: assert property (wr_at(8'h08) |-> ##1
		SECOND_AUX_CODE_OUT == $past(REG_WDATA_IN[6:4], 2) &&
		FIRST_AUX_CODE_OUT == $past(REG_WDATA_IN[2:0], 2)) else $error("aux codes wrong");
	go_busy_a: assert property (REG_WRITE_IN && REG_ADDR_IN == 8'h05 && REG_WDATA_IN[7]
		|-> ##2 MOVE_BUSY_OUT) else $error("move did not start");
	fault_hold_a: assert property ($past(NRST_IN) |->
		PROCESSOR_RAIL_FAULT_FLAG_OUT == ($past(PROCESSOR_RAIL_UNDER_IN) && !MOVE_BUSY_OUT))
		else $error("fault flag wrong");
	unmapped_zero_a: assert property (REG_READ_IN &&
		(REG_ADDR_IN < 8'h04 || REG_ADDR_IN > 8'h08) |=> REG_RDATA_OUT == 8'h00)
		else $error("unmapped read not zero");
	code_still_a: assert property ($changed(PROCESSOR_RAIL_CODE_OUT) &&
		!PROCESSOR_PIN_SOURCE_OUT && !$past(PROCESSOR_PIN_SOURCE_OUT) |-> MOVE_BUSY_OUT)
		else $error("code moved without a move");
	pin_code_a: assert property (age_reg == 2'h3 && PROCESSOR_PIN_SOURCE_OUT &&
		$past(PROCESSOR_PIN_SOURCE_OUT) && $stable(PROCESSOR_DEFAULT_PIN_IN) &&
		$past(PROCESSOR_DEFAULT_PIN_IN, 2) == PROCESSOR_DEFAULT_PIN_IN &&
		$past(PROCESSOR_DEFAULT_PIN_IN, 3) == PROCESSOR_DEFAULT_PIN_IN |->
		PROCESSOR_RAIL_CODE_OUT == (PROCESSOR_DEFAULT_PIN_IN ? 5'h1E : 5'h14))
		else $error("pin default code wrong");
endmodule
bind pcc_converter_regs pcc_regs_checker #(.SLOW_CYCLES(SLOW_CYCLES)) u_pcc_regs_checker (.*);

/* File: tb_pcc_converter_regs.sv */
module tb_pcc_converter_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        pin = 1'b0;
	logic        under = 1'b0;
	logic [3:0]  ev = 4'h0; // bucks off, warm reset, por, backup low
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic [4:0]  code;
	logic        busy;
	logic        fault;
	logic        pend = 1'b0;
	logic [7:0]  expq [$];
	logic [31:0] seed = 32'h4D6AD634;
	int          mismatches = 0;
	int          checks = 0;
	logic [7:0]  rv [6] = '{8'hB0, 8'h40, 8'h14, 8'h06, 8'h23, 8'h00};
	logic [7:0]  mk [6] = '{8'hFF, 8'hC7, 8'h1F, 8'h07, 8'h77, 8'h00};
	pcc_host_model u_pcc_host_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
	pcc_converter_regs #(.SLOW_CYCLES(64)) u_pcc_converter_regs (
		.CLOCK_IN(clk), .NRST_IN(nrst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WRITE_IN(wr), .REG_READ_IN(rd), .REG_RDATA_OUT(rdata),
		.PROCESSOR_DEFAULT_PIN_IN(pin), .SYSTEM_BUCK_ENABLED_IN(!ev[0]),
		.PROCESSOR_BUCK_ENABLED_IN(!ev[0]), .WARM_RESET_N_IN(!ev[1]),
		.POWER_ON_RESET_ACTIVE_IN(ev[2]), .BACKUP_RAIL_LOW_IN(ev[3]),
		.PROCESSOR_RAIL_UNDER_IN(under), .LOW_RIPPLE_OUT(), .FORCED_FIXED_FREQUENCY_OUT(),
		.BUCK_BLEED_OUT(), .PROCESSOR_RAIL_CODE_OUT(code), .PROCESSOR_PIN_SOURCE_OUT(),
		.MOVE_BUSY_OUT(busy), .PROCESSOR_RAIL_FAULT_FLAG_OUT(fault),
		.FIRST_AUX_CODE_OUT(), .SECOND_AUX_CODE_OUT());
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize;
		if (mismatches == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// reads note their expected byte for the watcher
	task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d);
		if (!w) expq.push_back(d);
		u_pcc_host_model.acc(w, a, d);
	endtask
	// bounded wait for the move flag to drop
	task automatic settle;
		int n;
		repeat (2) @(negedge clk);
		for (n = 0; busy !== 1'b0 && n < 5000; n++) @(negedge clk);
		if (n == 5000) begin
			mismatches++;
			summarize();
		end
		repeat (2) @(negedge clk);
	endtask
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) pend <= rd;
	// read data is registered, so it is judged at the next falling edge
	always @(negedge clk) begin
		if (pend) chk("read data", expq.pop_front(), rdata);
	end
	initial begin
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		// reset value, random write and masked read-back, one unmapped byte too
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			rw(1'b0, 8'h04 + 8'(k), rv[k]);
			rw(1'b1, 8'h04 + 8'(k), seed[7:0] & 8'h7F);
			rw(1'b0, 8'h04 + 8'(k), seed[7:0] & 8'h7F & mk[k]);
		end
		// immediate move to the top code, then one slow step with the fault input up
		rw(1'b1, 8'h05, 8'h00);
		rw(1'b1, 8'h06, 8'h1F);
		rw(1'b1, 8'h07, 8'h07);
		rw(1'b1, 8'h05, 8'h80);
		settle();
		chk("rail code", 8'h1F, {3'h0, code});
		under = 1'b1;
		rw(1'b1, 8'h06, 8'h1E);
		rw(1'b1, 8'h07, 8'h00);
		rw(1'b1, 8'h05, 8'h80);
		repeat (30) @(negedge clk);
		chk("rail code", 8'h1F, {3'h0, code});
		chk("fault flag", 8'h00, {7'h0, fault});
		settle();
		chk("rail code", 8'h1E, {3'h0, code});
		chk("fault flag", 8'h01, {7'h0, fault});
		rw(1'b0, 8'h05, 8'h00);
		// each reload event returns the target to its pin default
		for (int i = 0; i < 4; i++) begin
			rw(1'b1, 8'h06, 8'h0A);
			ev[i] = 1'b1;
			repeat (2) @(negedge clk);
			ev[i] = 1'b0;
			rw(1'b0, 8'h06, 8'h14);
		end
		// pin source follows the pin; lockout reloads the high default
		rw(1'b1, 8'h05, 8'h40);
		pin = 1'b1;
		repeat (4) @(negedge clk);
		chk("rail code", 8'h1E, {3'h0, code});
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		rw(1'b0, 8'h06, 8'h1E);
		repeat (2) @(negedge clk);
		summarize();
	end
endmodule
